// File: epc_map.vh
// Register offsets, field positions and reset values of the pin interrupt unit.
`ifndef EPC_MAP_VH
`define EPC_MAP_VH
// Register indices; each register holds one aligned word on the bus.
`define EPC_IDX_GROUP_EN 8'h68
`define EPC_IDX_MASK_LOW 8'h6b
`define EPC_IDX_MASK_MID 8'h6c
`define EPC_IDX_MASK_HIGH 8'h6d
`define EPC_IDX_LINE_EN 8'h70
`define EPC_IDX_SENSE 8'h74
`define EPC_IDX_LINE_FLAGS 8'h78
`define EPC_IDX_GROUP_FLAGS 8'h7c
// Byte addresses, four times the index.
`define EPC_OFF_GROUP_EN 9'h1a0
`define EPC_OFF_MASK_LOW 9'h1ac
`define EPC_OFF_MASK_MID 9'h1b0
`define EPC_OFF_MASK_HIGH 9'h1b4
`define EPC_OFF_LINE_EN 9'h1c0
`define EPC_OFF_SENSE 9'h1d0
`define EPC_OFF_LINE_FLAGS 9'h1e0
`define EPC_OFF_GROUP_FLAGS 9'h1f0
`define EPC_RST_ADDR 9'h000
`define EPC_RST_BYTE 8'h00
`define EPC_SENSE_LOW 2'h0
`define EPC_SENSE_ANY 2'h1
`define EPC_SENSE_FALL 2'h2
`define EPC_SENSE_RISE 2'h3
`define EPC_MASK_MID_BITS 8'h7f
`define EPC_RESP_OKAY 2'h0
`define EPC_RESP_SLVERR 2'h2
`endif

// File: epc_irq_unit.v
// External line and pin-change interrupt unit with an AXI4-Lite slave.
//
// How it works
// [RQ1] Line request needs line enable and global enable.
// [RQ2] Two sense bits pick edge, change or level.
// [RQ3] Pin activity counts even when driven as output.
// [RQ4] Each external line has its own vector request.
// [RQ5] Line edge sets flag bit 0 or 1.
// [RQ6] Vector ack or written one clears flag.
// [RQ7] Level-sensed line keeps its flag at zero.
// [RQ8] Unused bit positions read as zero.
// [RQ9] Three group enables at 0x68, reset zero.
// [RQ10] Lines map to high, mid, low groups.
// [RQ11] Each group has its own vector request.
// [RQ12] Group change sets group flag, gated request.
// [RQ13] Vector ack or written one clears group flag.
// [RQ14] Per-line masks at 0x6d, 0x6c, 0x6b.
// [RQ15] Cleared mask bit disables that line.
// [RQ16] Sense 00 low, 01 any, 10 fall, 11 rise.
// [RQ17] Pulses over one clock are always caught.
// [RQ18] Low level requests while line stays low.
// [RQ19] Changes are seen from raw pins, no state; the code detects them from the registered synced samples instead.
// [RQ20] Compare synced samples, OR masked differences.
`include "epc_map.vh"
module epc_irq_unit #(
    parameter NUM_LINES = 2,
    parameter NUM_PINS = 24
) (
    input wire aclk,
    input wire aresetn,
    input wire [NUM_LINES-1:0] ext_irq_pins,
    input wire [NUM_PINS-1:0] change_pins,
    input wire processor_status_ie,
    input wire [NUM_LINES-1:0] ext_vector_ack,
    input wire [2:0] group_vector_ack,
    output wire [NUM_LINES-1:0] ext_vector_req,
    output wire [2:0] group_vector_req,
    output wire [NUM_LINES-1:0] ext_level_wake,
    output wire pin_change_wake,
    input wire [8:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [8:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

////////////////////////////////////////////////////////////////////////////
// Input synchronisers and change detection.

reg [NUM_LINES-1:0] line_meta_reg;
reg [NUM_LINES-1:0] line_sync_reg;
reg [NUM_LINES-1:0] line_prev_reg;
reg [NUM_PINS-1:0] pin_meta_reg;
reg [NUM_PINS-1:0] pin_sync_reg;
reg [NUM_PINS-1:0] pin_prev_reg;

// Pins are sampled regardless of port direction, so writes to an output
// pin raise requests too; that is the software interrupt path.
always @(posedge aclk) begin // see [RQ3]
    if (!aresetn) begin
        line_meta_reg <= {NUM_LINES{1'b1}};
        line_sync_reg <= {NUM_LINES{1'b1}};
        line_prev_reg <= {NUM_LINES{1'b1}};
        pin_meta_reg <= {NUM_PINS{1'b0}};
        pin_sync_reg <= {NUM_PINS{1'b0}};
        pin_prev_reg <= {NUM_PINS{1'b0}};
    end else begin
        line_meta_reg <= ext_irq_pins;
        line_sync_reg <= line_meta_reg;
        line_prev_reg <= line_sync_reg;
        pin_meta_reg <= change_pins;
        pin_sync_reg <= pin_meta_reg;
        pin_prev_reg <= pin_sync_reg;
    end
end

////////////////////////////////////////////////////////////////////////////
// Registers.

reg [2:0] pin_group_enable_reg;
reg [7:0] pin_mask_low_group_reg;
reg [6:0] pin_mask_mid_group_reg;
reg [7:0] pin_mask_high_group_reg;
reg [NUM_LINES-1:0] ext_line_enables_reg;
reg [2*NUM_LINES-1:0] ext_sense_control_reg;
reg [NUM_LINES-1:0] external_line_flags_reg;
reg [2:0] pin_group_flags_reg;
reg [NUM_LINES-1:0] line_flags_next;
reg [2:0] group_flags_next;
reg [NUM_LINES-1:0] line_event;
reg [1:0] sense;
integer i;

// Any pin that toggles between two synced samples and is unmasked counts;
// the one-cycle compare catches every pulse longer than a clock period.
wire [NUM_PINS-1:0] pin_diff = pin_sync_reg ^ pin_prev_reg; // see [RQ20]
wire [23:0] mask_all = {pin_mask_high_group_reg, 1'b0,
                        pin_mask_mid_group_reg, pin_mask_low_group_reg};
wire [23:0] pin_hit = pin_diff & mask_all; // see [RQ15]
// Pin 15 has no mask bit and never contributes.
wire [2:0] group_event = {|pin_hit[23:16], |pin_hit[14:8],
                          |pin_hit[7:0]}; // see [RQ10]

// Line edge and level decode per sense setting.
always @* begin
    line_event = {NUM_LINES{1'b0}};
    sense = `EPC_SENSE_LOW;
    for (i = 0; i < NUM_LINES; i = i + 1) begin
        sense = ext_sense_control_reg[2*i +: 2];
        case (sense) // see [RQ16] see [RQ2] see [RQ17]
            `EPC_SENSE_ANY: line_event[i] = line_sync_reg[i] ^
                                             line_prev_reg[i];
            `EPC_SENSE_FALL: line_event[i] = !line_sync_reg[i] &&
                                              line_prev_reg[i];
            `EPC_SENSE_RISE: line_event[i] = line_sync_reg[i] &&
                                              !line_prev_reg[i];
            default: line_event[i] = 1'b0;
        endcase
    end
end

wire [NUM_LINES-1:0] line_is_level;
genvar g;
generate
    for (g = 0; g < NUM_LINES; g = g + 1) begin : g_lvl
        assign line_is_level[g] =
            ext_sense_control_reg[2*g +: 2] == `EPC_SENSE_LOW;
    end
endgenerate

////////////////////////////////////////////////////////////////////////////
// AXI4-Lite slave: address and data may arrive in either order.

reg aw_held_reg;
reg w_held_reg;
reg [8:0] aw_addr_reg;
reg [31:0] w_data_reg;
reg [3:0] w_strb_reg;

assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;

wire aw_now = aw_held_reg || s_axi_awvalid;
wire w_now = w_held_reg || s_axi_wvalid;
wire wr_fire = aw_now && w_now && !s_axi_bvalid;
wire [8:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
wire [3:0] wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
wire wr_lane0 = wr_fire && wr_strb[0];
wire [7:0] wb = wr_data[7:0];
wire wr_known = wr_addr == `EPC_OFF_GROUP_EN ||
                wr_addr == `EPC_OFF_MASK_LOW ||
                wr_addr == `EPC_OFF_MASK_MID ||
                wr_addr == `EPC_OFF_MASK_HIGH ||
                wr_addr == `EPC_OFF_LINE_EN ||
                wr_addr == `EPC_OFF_SENSE ||
                wr_addr == `EPC_OFF_LINE_FLAGS ||
                wr_addr == `EPC_OFF_GROUP_FLAGS;

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        aw_addr_reg <= `EPC_RST_ADDR;
        w_data_reg <= 32'h0000_0000;
        w_strb_reg <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `EPC_RESP_OKAY;
    end else begin
        if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? `EPC_RESP_OKAY : `EPC_RESP_SLVERR;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
end

// Register writes; flags are set by hardware with priority over clears.
always @* begin
    line_flags_next = (external_line_flags_reg & ~ext_vector_ack) |
                      line_event; // see [RQ5] see [RQ6]
    if (wr_lane0 && wr_addr == `EPC_OFF_LINE_FLAGS)
        line_flags_next = (external_line_flags_reg & ~ext_vector_ack &
                           ~wb[NUM_LINES-1:0]) | line_event; // see [RQ6]
    line_flags_next = line_flags_next & ~line_is_level; // see [RQ7]
    group_flags_next = (pin_group_flags_reg & ~group_vector_ack) |
                       group_event; // see [RQ12] see [RQ13]
    if (wr_lane0 && wr_addr == `EPC_OFF_GROUP_FLAGS)
        group_flags_next = (pin_group_flags_reg & ~group_vector_ack &
                            ~wb[2:0]) | group_event; // see [RQ13]
end

always @(posedge aclk) begin
    if (!aresetn) begin
        pin_group_enable_reg <= 3'h0; // see [RQ9]
        pin_mask_low_group_reg <= `EPC_RST_BYTE; // see [RQ14]
        pin_mask_mid_group_reg <= 7'h00;
        pin_mask_high_group_reg <= `EPC_RST_BYTE;
        ext_line_enables_reg <= {NUM_LINES{1'b0}};
        ext_sense_control_reg <= {2*NUM_LINES{1'b0}};
        external_line_flags_reg <= {NUM_LINES{1'b0}};
        pin_group_flags_reg <= 3'h0;
    end else begin
        external_line_flags_reg <= line_flags_next;
        pin_group_flags_reg <= group_flags_next;
        if (wr_lane0) begin
            case (wr_addr)
                `EPC_OFF_GROUP_EN: pin_group_enable_reg <= wb[2:0];
                `EPC_OFF_MASK_LOW: pin_mask_low_group_reg <= wb;
                `EPC_OFF_MASK_MID: pin_mask_mid_group_reg <= wb[6:0];
                `EPC_OFF_MASK_HIGH: pin_mask_high_group_reg <= wb;
                `EPC_OFF_LINE_EN: ext_line_enables_reg <= wb[NUM_LINES-1:0];
                `EPC_OFF_SENSE:
                    ext_sense_control_reg <= wb[2*NUM_LINES-1:0];
                default: ;
            endcase
        end
    end
end

// Read path; unused bits return zero.
reg [7:0] rd_byte;
reg rd_known;
always @* begin
    rd_byte = `EPC_RST_BYTE;
    rd_known = 1'b1;
    case (s_axi_araddr) // see [RQ8]
        `EPC_OFF_GROUP_EN: rd_byte = {5'h00, pin_group_enable_reg};
        `EPC_OFF_MASK_LOW: rd_byte = pin_mask_low_group_reg;
        `EPC_OFF_MASK_MID: rd_byte = {1'b0, pin_mask_mid_group_reg} &
                                     `EPC_MASK_MID_BITS;
        `EPC_OFF_MASK_HIGH: rd_byte = pin_mask_high_group_reg;
        `EPC_OFF_LINE_EN: rd_byte = {6'h00, ext_line_enables_reg};
        `EPC_OFF_SENSE: rd_byte = {4'h0, ext_sense_control_reg};
        `EPC_OFF_LINE_FLAGS: rd_byte = {6'h00, external_line_flags_reg};
        `EPC_OFF_GROUP_FLAGS: rd_byte = {5'h00, pin_group_flags_reg};
        default: rd_known = 1'b0;
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `EPC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_known ? `EPC_RESP_OKAY : `EPC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////
// Requests to the core.

// Level lines request while held low; edge lines request from the flag.
wire [NUM_LINES-1:0] line_pending = (line_is_level & ~line_sync_reg) |
                                    external_line_flags_reg; // see [RQ18]
assign ext_vector_req = line_pending & ext_line_enables_reg &
    {NUM_LINES{processor_status_ie}}; // see [RQ1] see [RQ4] see [RQ5]
assign group_vector_req = pin_group_flags_reg & pin_group_enable_reg &
    {3{processor_status_ie}}; // see [RQ9] see [RQ11] see [RQ12]

// Wake paths for the power controller: ext_level_wake is unclocked, for sleep with the clock stopped,
// and bypasses the synchronisers; pin_change_wake is built from the synced samples.
assign ext_level_wake = line_is_level & ext_line_enables_reg &
                        ~ext_irq_pins; // see [RQ18]
assign pin_change_wake = |(pin_diff & mask_all &
    {{8{pin_group_enable_reg[2]}}, {8{pin_group_enable_reg[1]}},
     {8{pin_group_enable_reg[0]}}}); // see [RQ19]

endmodule // epc_irq_unit

// File: epc_irq_props.sv
// Concurrent checks on the ports of the pin interrupt unit.
module epc_irq_props #(
    parameter NUM_LINES = 2
) (
    input wire aclk,
    input wire aresetn,
    input wire [NUM_LINES-1:0] ext_irq_pins,
    input wire processor_status_ie,
    input wire [NUM_LINES-1:0] ext_vector_req,
    input wire [2:0] group_vector_req,
    input wire [NUM_LINES-1:0] ext_level_wake,
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_ext_req_gate: assert property (
        |ext_vector_req |-> processor_status_ie) else $error("line req");
    a_grp_req_gate: assert property (
        |group_vector_req |-> processor_status_ie) else $error("group req");
    a_level_wake_pin: assert property (
        ext_level_wake[0] |-> !ext_irq_pins[0]) else $error("level wake");
    a_rdata_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("rdata");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid");
    a_write_refused: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("aw");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |-> ##1 s_axi_rvalid) else $error("read answer");
endmodule // epc_irq_props
bind epc_irq_unit epc_irq_props #(.NUM_LINES(NUM_LINES)) u_props (
    .aclk(aclk), .aresetn(aresetn), .ext_irq_pins(ext_irq_pins),
    .processor_status_ie(processor_status_ie),
    .ext_vector_req(ext_vector_req), .group_vector_req(group_vector_req),
    .ext_level_wake(ext_level_wake), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

// File: epc_cpu_model.sv
// Processor side model that runs vector routines by acknowledging requests.
module epc_cpu_model (
    input wire aclk,
    input wire aresetn,
    input wire ack_en,
    input wire [1:0] ext_vector_req,
    input wire [2:0] group_vector_req,
    output logic [1:0] ext_vector_ack,
    output logic [2:0] group_vector_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    // One pulse per flag request, then a gap, so it is acked once; a held level request is acked every other cycle.
    always @(posedge aclk) begin
        if (!aresetn || !ack_en) begin
            ext_vector_ack <= 2'h0;
            group_vector_ack <= 3'h0;
        end else begin
            ext_vector_ack <= ext_vector_req & ~ext_vector_ack;
            group_vector_ack <= group_vector_req & ~group_vector_ack;
        end
    end
endmodule // epc_cpu_model

// File: ext_pin_change_irq_unit_tb_top.sv
// Self-checking bench for the pin interrupt unit.
`include "epc_map.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module ext_pin_change_irq_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, ie = 0, ack_en = 0, pwake;
    logic awv = 0, awr, wv = 0, wr, bv, br = 0, arv = 0, arr, rv, rr = 0;
    logic [1:0] xpins = 2'h3, xack, xreq, lwake, bresp, rresp;
    logic [2:0] gack, greq;
    logic [23:0] cpins = 24'h0;
    logic [8:0] awa = 9'h0, ara = 9'h0;
    logic [31:0] wd = 32'h0, rd;
    int fail_count = 0, n_compared = 0;
    initial forever #12.5 aclk = ~aclk;
    epc_irq_unit uut (.aclk(aclk), .aresetn(aresetn), .ext_irq_pins(xpins),
        .change_pins(cpins), .processor_status_ie(ie), .ext_vector_ack(xack),
        .group_vector_ack(gack), .ext_vector_req(xreq), .group_vector_req(greq),
        .ext_level_wake(lwake), .pin_change_wake(pwake), .s_axi_awaddr(awa),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
    epc_cpu_model cpu (.aclk(aclk), .aresetn(aresetn), .ack_en(ack_en),
        .ext_vector_req(xreq), .group_vector_req(greq),
        .ext_vector_ack(xack), .group_vector_ack(gack));
    task automatic finish_test();
        $display("Mismatches %0d of %0d checks", fail_count, n_compared);
        if (fail_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic timed_out();
        fail_count++;
        finish_test();
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask
    // Bus tasks start right after a rising edge and return on one.
    task automatic wr_reg(input logic [8:0] a, input logic [31:0] d,
            input logic [1:0] er);
        int n;
        n = 0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awr === 1'b1) awv <= 1'b0;
            if (wr === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1 && n < 50);
        br <= 1'b0;
        if (n >= 50) timed_out();
        `CHK(bresp, er)
    endtask
    task automatic rd_chk(input logic [8:0] a, input logic [31:0] ed,
            input logic [1:0] er);
        int n;
        n = 0;
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arr === 1'b1) arv <= 1'b0;
        end while (rv !== 1'b1 && n < 50);
        rr <= 1'b0;
        if (n >= 50) timed_out();
        `CHK(rd, ed)
        `CHK(rresp, er)
    endtask
    task automatic t_regs();
        rd_chk(`EPC_OFF_GROUP_EN, 32'h0, 2'h0);
        rd_chk(`EPC_OFF_MASK_HIGH, 32'h0, 2'h0);
        wr_reg(`EPC_OFF_GROUP_EN, 32'hff, 2'h0);
        rd_chk(`EPC_OFF_GROUP_EN, 32'h7, 2'h0);
        wr_reg(`EPC_OFF_MASK_MID, 32'hff, 2'h0);
        rd_chk(`EPC_OFF_MASK_MID, 32'h7f, 2'h0);
        wr_reg(9'h040, 32'hff, `EPC_RESP_SLVERR);
        rd_chk(9'h040, 32'h0, `EPC_RESP_SLVERR);
    endtask
    task automatic t_groups();
        logic [8:0] mreg [3] = '{`EPC_OFF_MASK_LOW, `EPC_OFF_MASK_MID,
            `EPC_OFF_MASK_HIGH};
        int pin [3] = '{3, 8, 16};
        ie <= 1'b1;
        for (int g = 0; g < 3; g++) begin
            wr_reg(mreg[g], 32'h1 << (pin[g] % 8), 2'h0);
            cpins[pin[g] + 1] <= ~cpins[pin[g] + 1];
            cyc(3);
            `CHK(pwake, 1'b0)
            cyc(2);
            `CHK(greq, 3'h0)
            cpins[pin[g]] <= ~cpins[pin[g]];
            // The wake line stands for the one cycle of the synced change.
            cyc(3);
            `CHK(pwake, 1'b1)
            cyc(2);
            `CHK(greq, 3'h1 << g)
            wr_reg(`EPC_OFF_GROUP_FLAGS, 32'h1 << g, 2'h0);
            rd_chk(`EPC_OFF_GROUP_FLAGS, 32'h0, 2'h0);
        end
    endtask
    task automatic t_ext();
        logic [1:0] m;
        wr_reg(`EPC_OFF_LINE_EN, 32'h1, 2'h0);
        for (int k = 1; k < 4; k++) begin
            m = k;
            wr_reg(`EPC_OFF_SENSE, {30'h0, m}, 2'h0);
            wr_reg(`EPC_OFF_LINE_FLAGS, 32'h3, 2'h0);
            xpins[0] <= 1'b0;
            cyc(5);
            `CHK(xreq, {1'b0, m != `EPC_SENSE_RISE})
            wr_reg(`EPC_OFF_LINE_FLAGS, 32'h1, 2'h0);
            xpins[0] <= 1'b1;
            cyc(5);
            `CHK(xreq[0], m != `EPC_SENSE_FALL)
        end
        ack_en <= 1'b1;
        cyc(4);
        `CHK(xreq, 2'h0)
        ack_en <= 1'b0;
        ie <= 1'b0;
        xpins[0] <= 1'b0;
        cyc(5);
        xpins[0] <= 1'b1;
        cyc(5);
        `CHK(xreq, 2'h0)
        wr_reg(`EPC_OFF_LINE_FLAGS, 32'h0, 2'h0);
        rd_chk(`EPC_OFF_LINE_FLAGS, 32'h1, 2'h0);
        ie <= 1'b1;
        cyc(1);
        `CHK(xreq, 2'h1)
        wr_reg(`EPC_OFF_SENSE, 32'h0, 2'h0);
        xpins[0] <= 1'b0;
        cyc(4);
        `CHK(xreq, 2'h1)
        `CHK(lwake, 2'h1)
        rd_chk(`EPC_OFF_LINE_FLAGS, 32'h0, 2'h0);
        xpins[0] <= 1'b1;
        cyc(4);
        `CHK(xreq, 2'h0)
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_groups();
        t_ext();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        timed_out();
    end
endmodule // ext_pin_change_irq_unit_tb_top
